// ### core/adi_pkg.sv
// Purpose: constants and types for the audio dsp init sequencer
// Assumes: 10 MHz master clock on clk_i
// Notes:   register port is a simple addressed write/read port
// Function
// - latch pll mode pins at reset release
// - gate all subsystem clocks after reset
// - ten millisecond init period from reset
// - normal rate multipliers 64 to 512; the pins select dividers and core_mult_o is fixed at 56 here
// - dual halves, quad quarters multipliers; core_mult_o and pll_div_o do not change with the rate mode here
// - all locations writable except read-only; only the core rate, clock enable and core run registers store writes here
// - self boot from serial eeprom
// - subsystems enabled independently for power
// - pin codes select dividers 1,2,4,6,8
package adi_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned INIT_TIME_MS    = 10;
    localparam int unsigned INIT_CYCLES     = CLK_HZ / 1000 * INIT_TIME_MS;
    localparam logic [15:0] CORE_RATE_ADDR  = 16'hE220;
    localparam logic [15:0] CLK_EN_ADDR     = 16'hE221;
    localparam logic [15:0] CORE_RUN_ADDR   = 16'hE222;
    localparam logic [15:0] STATUS_ADDR     = 16'hE223;
    localparam logic [15:0] CORE_RATE_RST   = 16'h0000;
    localparam logic [15:0] PARAM_END       = 16'h0FFF;
    localparam logic [15:0] PROG_BASE       = 16'h2000;
    localparam logic [15:0] PROG_END        = 16'h2FFF;
    localparam logic [15:0] REG_LAST        = 16'hE24C;
    localparam int unsigned CORE_MULT       = 56;
    localparam int unsigned N_SUBSYS        = 5;
    localparam int unsigned SS_RATE_CONV    = 0;
    localparam int unsigned SS_SPDIF_RX     = 1;
    localparam int unsigned SS_SPDIF_TX     = 2;
    localparam int unsigned SS_AUX_ADC      = 3;
    localparam int unsigned SS_CORE         = 4;
    localparam logic [1:0]  RATE_NORMAL     = 2'h0;
    localparam logic [1:0]  RATE_DUAL       = 2'h1;
    localparam logic [1:0]  RATE_QUAD       = 2'h2;
    typedef enum logic [1:0] {ST_RESET, ST_INIT, ST_BOOT, ST_READY} adi_state_t;
endpackage

// ### core/adi_ctr_if.sv
// Purpose: init counter hookup
// Assumes: single clock
// Notes:   start is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface adi_ctr_if;
    logic start;
    logic done;
    modport ctl (output start, input done);
    modport cnt (input start, output done);
endinterface
`default_nettype wire

// ### core/adi_init_timer.sv
// Purpose: counts the init interval
// Assumes: terminal count given by parameter
// Notes:   done stays high until the next start
`timescale 1ns/1ps
`default_nettype none
module adi_init_timer #(
    parameter int unsigned TERM = 100_000
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    adi_ctr_if.cnt    ctr
);
    import adi_pkg::*;
    typedef struct packed {
        logic [31:0] cnt;
        logic        run;
        logic        done;
    } adi_tmr_t;
    adi_tmr_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (ctr.start) begin
            nxt_st.cnt  = 32'h0000_0000;
            nxt_st.run  = 1'b1;
            nxt_st.done = 1'b0;
        end else if (st_ff.run) begin
            if (st_ff.cnt == TERM - 1) begin
                nxt_st.run  = 1'b0;
                nxt_st.done = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ctr.done = st_ff.done;
endmodule
`default_nettype wire

// ### core/adi_init_seq.sv
// Purpose: reset release, pll strap capture, clock gating and core run
// Assumes: reset pin is synchronous to clk_i after the board reset logic
// Notes:   host must not write before init_done_o (stores are blocked)
`timescale 1ns/1ps
`default_nettype none
module adi_init_seq #(
    parameter int unsigned INIT_TERM = adi_pkg::INIT_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        pll_mode_pin_bit0_i,
    input  wire logic        pll_mode_pin_bit1_i,
    input  wire logic        pll_mode_pin_bit2_i,
    input  wire logic        boot_en_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o,
    output logic             rvalid_o,
    output logic             init_done_o,
    output logic      [3:0]  pll_div_o,
    output logic      [5:0]  core_mult_o,
    output logic      [1:0]  rate_mode_o,
    output logic      [4:0]  subsys_clk_en_o,
    output logic             core_run_o,
    output logic             boot_req_o
);
    import adi_pkg::*;

    typedef struct packed {
        adi_state_t  state;
        logic [2:0]  pll_pins;
        logic [3:0]  pll_div;
        logic [15:0] core_rate;
        logic [4:0]  clk_en;
        logic        core_run;
        logic        done;
        logic        boot_req;
        logic [15:0] rdata;
        logic        rvalid;
        logic        start;
    } adi_seq_t;
    adi_seq_t st_ff, nxt_st;

    adi_ctr_if ctr ();
    adi_init_timer #(.TERM(INIT_TERM)) u_timer (
        .clk_i   (clk_i),
        .resetn_i(resetn_i),
        .ctr     (ctr)
    );
    assign ctr.start = st_ff.start;

    // binary pin code to divider; unused codes fall back to divide by 1
    function automatic logic [3:0] div_of(input logic [2:0] p);
        case (p)
            3'h0:    div_of = 4'h1;
            3'h1:    div_of = 4'h2;
            3'h2:    div_of = 4'h4;
            3'h3:    div_of = 4'h6;
            3'h4:    div_of = 4'h8;
            default: div_of = 4'h1;
        endcase
    endfunction

    logic wr_ok;
    always_comb begin
        // pre-init writes are dropped here; read-only addresses fall to the default of the decode below
        wr_ok = wr_i && st_ff.done;
    end

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.start  = 1'b0;
        nxt_st.rvalid = rd_i;
        case (st_ff.state)
            ST_RESET: begin
                // strap sampled at first edge after release
                nxt_st.pll_pins = {pll_mode_pin_bit2_i, pll_mode_pin_bit1_i,
                                   pll_mode_pin_bit0_i};
                nxt_st.pll_div  = div_of({pll_mode_pin_bit2_i,
                                          pll_mode_pin_bit1_i,
                                          pll_mode_pin_bit0_i});
                nxt_st.clk_en   = '0;
                nxt_st.start    = 1'b1;
                nxt_st.state    = ST_INIT;
            end
            ST_INIT: begin
                if (ctr.done) begin
                    nxt_st.done = 1'b1;
                    if (boot_en_i) begin
                        nxt_st.boot_req = 1'b1;
                        nxt_st.state    = ST_BOOT;
                    end else begin
                        nxt_st.state = ST_READY;
                    end
                end
            end
            ST_BOOT: begin
                // the eeprom loader drives the same write port
                if (!boot_en_i) begin
                    nxt_st.boot_req = 1'b0;
                    nxt_st.state    = ST_READY;
                end
            end
            ST_READY: begin
            end
            default: nxt_st.state = ST_RESET;
        endcase
        if (wr_ok) begin
            case (addr_i)
                CORE_RATE_ADDR: nxt_st.core_rate = wdata_i;
                CLK_EN_ADDR:    nxt_st.clk_en    = wdata_i[4:0];
                CORE_RUN_ADDR:  nxt_st.core_run  = wdata_i[0];
                default: ;
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                CORE_RATE_ADDR: nxt_st.rdata = st_ff.core_rate;
                CLK_EN_ADDR:    nxt_st.rdata = {11'h000, st_ff.clk_en};
                CORE_RUN_ADDR:  nxt_st.rdata = {15'h0000, st_ff.core_run};
                STATUS_ADDR:    nxt_st.rdata = {9'h000, st_ff.pll_pins,
                                                st_ff.boot_req, 2'h0,
                                                st_ff.done};
                default:        nxt_st.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff           <= '0;
            st_ff.state     <= ST_RESET;
            st_ff.pll_div   <= 4'h1;
            st_ff.core_rate <= CORE_RATE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // core clock needs its subsystem clock too; run alone cannot start it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            core_run_o <= 1'b0;
        end else begin
            core_run_o <= nxt_st.core_run & nxt_st.clk_en[SS_CORE];
        end
    end

    assign rdata_o         = st_ff.rdata;
    assign rvalid_o        = st_ff.rvalid;
    assign init_done_o     = st_ff.done;
    assign pll_div_o       = st_ff.pll_div;
    assign core_mult_o     = 6'(CORE_MULT);
    assign rate_mode_o     = st_ff.core_rate[1:0];
    assign subsys_clk_en_o = st_ff.clk_en;
    assign boot_req_o      = st_ff.boot_req;
endmodule
`default_nettype wire

// ### test/adi_host_model.sv
// Purpose: host side of the register port
// Assumes: one request at a time
// Notes:   released address shows its inverse
`timescale 1ns/1ps
`default_nettype none
module adi_host_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [15:0] addr_o,
    output logic      [15:0] wdata_o
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 16'h0000;
        wdata_o = 16'h0000;
    end
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// ### test/adi_init_seq_checker.sv
// Purpose: port checks for adi_init_seq
// Assumes: INIT_TERM handed on by bind
// Notes:   pll pins only move in reset
`timescale 1ns/1ps
`default_nettype none
module adi_init_seq_checker
    import adi_pkg::*;
#(
    parameter int unsigned INIT_TERM = 20
) (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        pll_mode_pin_bit0_i,
    input wire logic        pll_mode_pin_bit1_i,
    input wire logic        pll_mode_pin_bit2_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        rvalid_o,
    input wire logic        init_done_o,
    input wire logic [3:0]  pll_div_o,
    input wire logic [1:0]  rate_mode_o,
    input wire logic [4:0]  subsys_clk_en_o,
    input wire logic        core_run_o
);
    localparam logic [3:0] DIV [5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
    logic [2:0]  pins;
    logic [31:0] cnt_ff;
    assign pins = {pll_mode_pin_bit2_i, pll_mode_pin_bit1_i,
                   pll_mode_pin_bit0_i};
    // saturates so a long run never wraps back to zero
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            cnt_ff <= '0;
        else if (cnt_ff < INIT_TERM + 4)
            cnt_ff <= cnt_ff + 1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_wr(logic [15:0] a);
        wr_i && init_done_o && addr_i == a;
    endsequence
    a_div_map: assert property (init_done_o && pins < 5 |->
        pll_div_o == DIV[pins]) else $error("divider mismatch");
    a_done_time: assert property (
        init_done_o == (cnt_ff >= INIT_TERM + 3))
        else $error("init done timing");
    a_gate_init: assert property (!init_done_o |->
        subsys_clk_en_o == 5'h00 && !core_run_o)
        else $error("clock not gated");
    a_clk_write: assert property (s_wr(CLK_EN_ADDR) |=>
        {11'h000, subsys_clk_en_o} == ($past(wdata_i) & 16'h001F))
        else $error("clock enable write");
    a_rate_write: assert property (s_wr(CORE_RATE_ADDR) |=>
        {14'h0000, rate_mode_o} == ($past(wdata_i) & 16'h0003))
        else $error("rate write");
    a_run_write: assert property (s_wr(CORE_RUN_ADDR) |=>
        core_run_o == ($past(wdata_i[0]) && subsys_clk_en_o[4]))
        else $error("run write");
    a_ro_status: assert property (s_wr(STATUS_ADDR) |=>
        $stable({subsys_clk_en_o, rate_mode_o, core_run_o}))
        else $error("status written");
    a_read_valid: assert property (rvalid_o == $past(rd_i))
        else $error("read valid timing");
endmodule
`default_nettype wire

// ### test/adi_init_seq_tb.sv
// Purpose: bench for adi_init_seq
// Assumes: INIT_TERM cut to 20 cycles
// Notes:   all bus cycles go through the host model
`timescale 1ns/1ps
`default_nettype none
module adi_init_seq_tb;
    import adi_pkg::*;
    localparam int unsigned T = 20;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        boot = 1'b0;
    logic [2:0]  pins = 3'h0;
    logic        wr, rd, rv, done, run, breq;
    logic [15:0] addr, wd, rdat;
    logic [3:0]  div;
    logic [5:0]  mult;
    logic [1:0]  rate;
    logic [4:0]  en;
    int          failures = 0;
    int          check_count = 0;
    int          cyc = 0;
    always #50 clk = ~clk;
    adi_init_seq #(.INIT_TERM(T)) i_adi_init_seq (.clk_i(clk),
        .resetn_i(rstn), .pll_mode_pin_bit0_i(pins[0]),
        .pll_mode_pin_bit1_i(pins[1]), .pll_mode_pin_bit2_i(pins[2]),
        .boot_en_i(boot), .wr_i(wr), .rd_i(rd), .addr_i(addr),
        .wdata_i(wd), .rdata_o(rdat), .rvalid_o(rv), .init_done_o(done),
        .pll_div_o(div), .core_mult_o(mult), .rate_mode_o(rate),
        .subsys_clk_en_o(en), .core_run_o(run), .boot_req_o(breq));
    adi_host_model i_adi_host_model (.clk_i(clk), .rdata_i(rdat),
        .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd));
    task automatic chk(input logic [15:0] s, e, input string n);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic results;
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic rst(input logic [2:0] p);
        @(posedge clk);
        rstn <= 1'b0;
        pins <= p;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
    endtask
    task automatic w(input logic [15:0] a, d);
        i_adi_host_model.wr(a, d);
        @(negedge clk);
    endtask
    task automatic t_init;
        rst(3'h0);
        // deliberately early store, must be dropped
        i_adi_host_model.wr(CLK_EN_ADDR, 16'h001F);
        repeat (T - 1) @(posedge clk);
        @(negedge clk);
        chk(16'(done), 16'h0000, "done early");
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(16'(done), 16'h0001, "done");
        chk(16'(en), 16'h0000, "gated");
    endtask
    task automatic t_setup;
        logic [15:0] d;
        w(CLK_EN_ADDR, 16'h0015);
        chk(16'(en), 16'h0015, "clk en");
        w(CORE_RUN_ADDR, 16'h0000);
        chk(16'(run), 16'h0000, "run off");
        w(PROG_END, 16'h1234);
        chk(16'(en), 16'h0015, "bulk load");
        for (int m = 0; m < 3; m++) begin
            w(CORE_RATE_ADDR, 16'(m));
            chk(16'(rate), 16'(m), "rate");
        end
        w(STATUS_ADDR, 16'hFFFF);
        chk(16'(en), 16'h0015, "status ro");
        i_adi_host_model.rd(CORE_RATE_ADDR, d);
        chk(d, 16'h0002, "rate read");
        w(CORE_RUN_ADDR, 16'h0001);
        chk(16'(run), 16'h0001, "run on");
        // small parameter tweak while running stands in for a safeload
        w(PARAM_END, 16'h0001);
        chk(16'(run), 16'h0001, "run kept");
        w(CLK_EN_ADDR, 16'h000A);
        chk(16'(run), 16'h0000, "core clk off");
    endtask
    task automatic t_straps;
        logic [3:0] dv [5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
        for (int k = 0; k < 5; k++) begin
            rst(3'(k));
            repeat (T + 3) @(posedge clk);
            @(negedge clk);
            chk(16'(div), 16'(dv[k]), "divider");
            chk(16'(mult), 16'h0038, "mult");
        end
    endtask
    task automatic t_boot;
        @(posedge clk);
        boot <= 1'b1;
        rst(3'h0);
        repeat (T + 4) @(posedge clk);
        @(negedge clk);
        chk(16'(breq), 16'h0001, "boot req");
        @(posedge clk);
        boot <= 1'b0;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            failures++;
            results();
        end
    end
    initial begin
        t_init();
        t_setup();
        t_straps();
        t_boot();
        results();
    end
endmodule
bind adi_init_seq adi_init_seq_checker #(.INIT_TERM(INIT_TERM)) i_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .wr_i(wr_i), .rd_i(rd_i),
    .pll_mode_pin_bit0_i(pll_mode_pin_bit0_i), .addr_i(addr_i),
    .pll_mode_pin_bit1_i(pll_mode_pin_bit1_i), .wdata_i(wdata_i),
    .pll_mode_pin_bit2_i(pll_mode_pin_bit2_i), .rvalid_o(rvalid_o),
    .init_done_o(init_done_o), .pll_div_o(pll_div_o),
    .rate_mode_o(rate_mode_o), .subsys_clk_en_o(subsys_clk_en_o),
    .core_run_o(core_run_o));
`default_nettype wire
